// file: fuse_shadow_defines.vh
`ifndef FUSE_SHADOW_DEFINES_VH
`define FUSE_SHADOW_DEFINES_VH

// Register offsets on the host control interface (9-bit, page 2 at 0x100)
`define REG_PAGE_SELECT 9'h100
`define REG_FUSE_CTRL 9'h101
`define REG_FUSE_POINTER 9'h102
`define REG_FUSE_WORD 9'h103
`define APP_FIRST 9'h104
`define APP_LAST 9'h117
`define GEN_FIRST 9'h120
`define GEN_LAST 9'h134
`define ID_FIRST 9'h12b
`define ID_COUNT 9'h00a

// Shadow depths
`define APP_DEPTH 20
`define GEN_DEPTH 21

// Fuse array addresses of each load range; the word after a range holds its flags
`define FUSE_APP_FIRST 8'h04
`define FUSE_APP_FLAGS 8'h18
`define FUSE_GEN_FIRST 8'h20
`define FUSE_GEN_FLAGS 8'h35

// Field positions in the fuse control/status register
`define BIT_ID_WRITE_BLOCK 7
`define BIT_CONFIG_LOCK 6
`define BIT_APP_LOCK 5
`define BIT_GENERAL_LOCK 4
`define BIT_EMU_DONE 3
`define BIT_APP_RELOAD 2
`define BIT_GENERAL_RELOAD 1
`define BIT_READ_MARGIN 0

// Reset values
`define PAGE_SELECT_RESET 8'h00
`define FUSE_CTRL_RESET 8'h00

// Unlock sequence: one select write plus this many word writes
`define UNLOCK_WORDS 2'h3

`endif

// file: fuse_load_engine.v
`timescale 1ns/1ps
`default_nettype none

// Walks a contiguous fuse address range, one read at a time, and hands each
// word back as a shadow write. The last word of the range is the flag word.
module fuse_load_engine #(
  parameter AW = 8
) (
  input wire clk,
  input wire nrst,
  input wire start,
  input wire [AW-1:0] first,
  input wire [AW-1:0] last,
  input wire fuse_rvalid,
  input wire [7:0] fuse_rdata,
  output reg rd_req_q,
  output reg [AW-1:0] addr_q,
  output reg wr_valid_q,
  output reg [AW-1:0] wr_addr_q,
  output reg [7:0] wr_data_q,
  output reg busy_q,
  output reg done_q
);

  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_REQ = 2'h1;
  localparam [1:0] S_WAIT = 2'h2;

  reg [1:0] state_q; // Sequencer state
  reg [AW-1:0] last_q; // Range end latched at start

  //////////////////////////////////////////////////////////////////////////
  // Sequencer: one outstanding fuse read, so slow arrays simply stretch it
  always @(posedge clk) begin
    if (!nrst) begin
      state_q <= S_IDLE;
      rd_req_q <= 1'b0;
      addr_q <= {AW{1'b0}};
      last_q <= {AW{1'b0}};
      wr_valid_q <= 1'b0;
      wr_addr_q <= {AW{1'b0}};
      wr_data_q <= 8'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      rd_req_q <= 1'b0;
      wr_valid_q <= 1'b0;
      done_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          // Start only when idle; the caller holds start until busy
          if (start) begin
            addr_q <= first;
            last_q <= last;
            busy_q <= 1'b1;
            state_q <= S_REQ;
          end
        end
        S_REQ: begin
          rd_req_q <= 1'b1;
          state_q <= S_WAIT;
        end
        S_WAIT: begin
          if (fuse_rvalid) begin
            wr_valid_q <= 1'b1;
            wr_addr_q <= addr_q;
            wr_data_q <= fuse_rdata;
            if (addr_q == last_q) begin
              // Flag word stored; the range is complete
              busy_q <= 1'b0;
              done_q <= 1'b1;
              state_q <= S_IDLE;
            end else begin
              addr_q <= addr_q + {{(AW-1){1'b0}}, 1'b1};
              state_q <= S_REQ;
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

endmodule // fuse_load_engine

`default_nettype wire

// file: fuse_shadow_load_control.v
// What this block does
// - Write block set makes ID registers read-only
// - Config lock flag is read-only status
// - App lock flag is read-only status
// - General lock flag is read-only status
// - Software sets emulation done; exit clears it
// - App trigger reloads app range plus lock
// - General trigger reloads range, block, lock
// - Margin bit selects marginal fuse read timing
// - Pointer register holds 8-bit fuse address
// - Word register data; select plus unlock bytes
`timescale 1ns/1ps
`default_nettype none
`include "fuse_shadow_defines.vh"

module fuse_shadow_load_control (
  input wire clk,
  input wire nrst,
  input wire [8:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_q,
  output reg reg_rvalid_q,
  input wire config_fuse_lock_in,
  input wire emul_active,
  input wire [7:0] fuse_rdata,
  input wire fuse_rvalid,
  output wire fuse_rd_q,
  output reg [7:0] fuse_addr_q,
  output reg fuse_read_margin_q,
  output reg fuse_prog_q,
  output reg [7:0] fuse_wdata_q,
  output reg [7:0] page_select_q
);

  //////////////////////////////////////////////////////////////////////////
  // Helpers
  function in_range;
    input [8:0] a;
    input [8:0] lo;
    input [8:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // State
  reg id_write_block_q; // Identification registers read-only when set
  reg config_fuse_lock_q; // Mirror of the configuration fuse lock
  reg app_fuse_lock_q; // Loaded with the application range
  reg general_fuse_lock_q; // Loaded with the general range
  reg emulation_load_done_q; // Set by software, cleared on emulation exit
  reg app_reload_trigger_q; // Held until the application load ends
  reg general_reload_trigger_q; // Held until the general load ends
  reg emul_active_q; // Previous emulation state, for exit detection
  reg [7:0] pointer_q; // Fuse array pointer
  reg [7:0] word_q; // Fuse array word
  reg selected_q; // Device selected by the pointer write
  reg [1:0] unlock_cnt_q; // Unlock bytes seen after selection
  reg load_is_gen_q; // Which range the engine is running
  reg [7:0] app_mem [0:`APP_DEPTH-1]; // Application shadow
  reg [7:0] gen_mem [0:`GEN_DEPTH-1]; // General shadow
  reg [7:0] rd_d; // Read mux
  integer i;

  wire eng_busy;
  wire eng_done;
  wire eng_wr;
  wire [7:0] eng_wr_addr;
  wire [7:0] eng_wr_data;
  wire [7:0] eng_addr;
  wire eng_start;
  wire eng_pick_gen;
  wire wr_ctrl;
  wire wr_ptr;
  wire wr_word;
  wire emul_exit;
  wire unlocked;
  wire [8:0] id_last;
  wire [7:0] eng_app_idx;
  wire [7:0] eng_gen_idx;
  wire [8:0] app_rd_idx;
  wire [8:0] gen_rd_idx;

  assign wr_ctrl = reg_wr && (reg_addr == `REG_FUSE_CTRL);
  assign wr_ptr = reg_wr && (reg_addr == `REG_FUSE_POINTER);
  assign wr_word = reg_wr && (reg_addr == `REG_FUSE_WORD);
  assign emul_exit = emul_active_q && !emul_active;
  assign unlocked = selected_q && (unlock_cnt_q == `UNLOCK_WORDS);
  assign id_last = `ID_FIRST + `ID_COUNT - 9'h001;
  // Application load goes first when both triggers are pending
  assign eng_pick_gen = !app_reload_trigger_q;
  assign eng_start = !eng_busy && !eng_done && (app_reload_trigger_q || general_reload_trigger_q);
  assign eng_app_idx = eng_wr_addr - `FUSE_APP_FIRST;
  assign eng_gen_idx = eng_wr_addr - `FUSE_GEN_FIRST;
  assign app_rd_idx = reg_addr - `APP_FIRST;
  assign gen_rd_idx = reg_addr - `GEN_FIRST;

  //////////////////////////////////////////////////////////////////////////
  // Fuse-to-shadow sequencer
  fuse_load_engine #(
    .AW(8)
  ) u_engine (
    .clk(clk),
    .nrst(nrst),
    .start(eng_start),
    .first(eng_pick_gen ? `FUSE_GEN_FIRST : `FUSE_APP_FIRST),
    .last(eng_pick_gen ? `FUSE_GEN_FLAGS : `FUSE_APP_FLAGS),
    .fuse_rvalid(fuse_rvalid),
    .fuse_rdata(fuse_rdata),
    .rd_req_q(fuse_rd_q),
    .addr_q(eng_addr),
    .wr_valid_q(eng_wr),
    .wr_addr_q(eng_wr_addr),
    .wr_data_q(eng_wr_data),
    .busy_q(eng_busy),
    .done_q(eng_done)
  );

  //////////////////////////////////////////////////////////////////////////
  // Control and status bits
  always @(posedge clk) begin
    if (!nrst) begin
      id_write_block_q <= 1'b0;
      config_fuse_lock_q <= 1'b0;
      app_fuse_lock_q <= 1'b0;
      general_fuse_lock_q <= 1'b0;
      emulation_load_done_q <= 1'b0;
      app_reload_trigger_q <= 1'b0;
      general_reload_trigger_q <= 1'b0;
      fuse_read_margin_q <= 1'b0;
      emul_active_q <= 1'b0;
      load_is_gen_q <= 1'b0;
      page_select_q <= `PAGE_SELECT_RESET;
    end else begin
      emul_active_q <= emul_active;
      // Config lock only follows the fuse; bus writes never touch it
      config_fuse_lock_q <= config_fuse_lock_in;
      if (reg_wr && (reg_addr == `REG_PAGE_SELECT)) begin
        page_select_q <= reg_wdata;
      end
      if (eng_start) begin
        load_is_gen_q <= eng_pick_gen;
      end
      // Margin timing is steered straight from software
      if (wr_ctrl) begin
        fuse_read_margin_q <= reg_wdata[`BIT_READ_MARGIN];
      end
      // Emulation done: exit clears, otherwise a software write stores it
      if (emul_exit) begin
        emulation_load_done_q <= 1'b0;
      end else if (wr_ctrl) begin
        emulation_load_done_q <= reg_wdata[`BIT_EMU_DONE];
      end
      // Triggers drop when their load finishes; a new set in that cycle wins
      if (wr_ctrl && reg_wdata[`BIT_APP_RELOAD]) begin
        app_reload_trigger_q <= 1'b1;
      end else if (eng_done && !load_is_gen_q) begin
        app_reload_trigger_q <= 1'b0;
      end
      if (wr_ctrl && reg_wdata[`BIT_GENERAL_RELOAD]) begin
        general_reload_trigger_q <= 1'b1;
      end else if (eng_done && load_is_gen_q) begin
        general_reload_trigger_q <= 1'b0;
      end
      // Lock flags come only from the fuse flag word of each range
      if (eng_wr && !load_is_gen_q && (eng_wr_addr == `FUSE_APP_FLAGS)) begin
        app_fuse_lock_q <= eng_wr_data[`BIT_APP_LOCK];
      end
      if (eng_wr && load_is_gen_q && (eng_wr_addr == `FUSE_GEN_FLAGS)) begin
        id_write_block_q <= eng_wr_data[`BIT_ID_WRITE_BLOCK];
        general_fuse_lock_q <= eng_wr_data[`BIT_GENERAL_LOCK];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Shadow storage: filled by loads, ID slots also by software
  always @(posedge clk) begin
    if (!nrst) begin
      for (i = 0; i < `APP_DEPTH; i = i + 1) begin
        app_mem[i] <= 8'h00;
      end
      for (i = 0; i < `GEN_DEPTH; i = i + 1) begin
        gen_mem[i] <= 8'h00;
      end
    end else begin
      if (eng_wr && !load_is_gen_q && (eng_wr_addr != `FUSE_APP_FLAGS)) begin
        app_mem[eng_app_idx[4:0]] <= eng_wr_data;
      end
      if (eng_wr && load_is_gen_q && (eng_wr_addr != `FUSE_GEN_FLAGS)) begin
        gen_mem[eng_gen_idx[4:0]] <= eng_wr_data;
      end else if (reg_wr && !id_write_block_q && in_range(reg_addr, `ID_FIRST, id_last)) begin
        // Writes are dropped silently while the block flag is set
        gen_mem[gen_rd_idx[4:0]] <= reg_wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Fuse pointer, word and unlock sequence
  always @(posedge clk) begin
    if (!nrst) begin
      pointer_q <= 8'h00;
      word_q <= 8'h00;
      selected_q <= 1'b0;
      unlock_cnt_q <= 2'h0;
      fuse_prog_q <= 1'b0;
      fuse_wdata_q <= 8'h00;
      fuse_addr_q <= 8'h00;
    end else begin
      fuse_prog_q <= 1'b0;
      // Array address follows the engine during loads, else the pointer
      fuse_addr_q <= eng_busy ? eng_addr : pointer_q;
      if (wr_ptr) begin
        pointer_q <= reg_wdata;
        // Writing the held word value to the pointer selects this device
        selected_q <= (reg_wdata == word_q);
        unlock_cnt_q <= 2'h0;
      end else if (wr_word) begin
        word_q <= reg_wdata;
        if (selected_q && !unlocked) begin
          unlock_cnt_q <= unlock_cnt_q + 2'h1;
        end else if (unlocked) begin
          fuse_prog_q <= 1'b1;
          fuse_wdata_q <= reg_wdata;
        end
      end else if (fuse_rvalid && !eng_busy) begin
        // Array answers that arrive while no load runs land in the word register
        word_q <= fuse_rdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read mux
  always @* begin
    rd_d = 8'h00;
    if (reg_addr == `REG_PAGE_SELECT) begin
      rd_d = page_select_q;
    end else if (reg_addr == `REG_FUSE_CTRL) begin
      rd_d = {id_write_block_q, config_fuse_lock_q, app_fuse_lock_q, general_fuse_lock_q,
              emulation_load_done_q, app_reload_trigger_q, general_reload_trigger_q,
              fuse_read_margin_q};
    end else if (reg_addr == `REG_FUSE_POINTER) begin
      rd_d = pointer_q;
    end else if (reg_addr == `REG_FUSE_WORD) begin
      rd_d = word_q;
    end else if (in_range(reg_addr, `APP_FIRST, `APP_LAST)) begin
      rd_d = app_mem[app_rd_idx[4:0]];
    end else if (in_range(reg_addr, `GEN_FIRST, `GEN_LAST)) begin
      rd_d = gen_mem[gen_rd_idx[4:0]];
    end
  end

  // Registered read answer, one cycle after the strobe
  always @(posedge clk) begin
    if (!nrst) begin
      reg_rdata_q <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        reg_rdata_q <= rd_d;
      end
    end
  end

endmodule // fuse_shadow_load_control

`default_nettype wire

// file: fuse_shadow_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the register port and the fuse array side of the shadow block
module fuse_shadow_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [8:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic reg_rvalid_q,
  input wire logic config_fuse_lock_in,
  input wire logic emul_active,
  input wire logic fuse_rd_q,
  input wire logic [7:0] fuse_addr_q,
  input wire logic fuse_read_margin_q,
  input wire logic fuse_prog_q,
  input wire logic [7:0] fuse_wdata_q,
  input wire logic [7:0] page_select_q
);
  // One clock domain, so one clocking and one disable for all
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////
  a_read_answer: assert property (reg_rd |=> reg_rvalid_q)
    else $error("Read strobe got no answer");
  a_read_quiet: assert property (!reg_rd |=> !reg_rvalid_q)
    else $error("Read answer without a strobe");
  a_margin_follow: assert property (
    reg_wr && reg_addr == 9'h101 |=> fuse_read_margin_q == $past(reg_wdata[0]))
    else $error("Margin select does not follow its bit");
  // Input held two cycles, so the one-cycle mirror delay cannot matter
  a_config_mirror: assert property (
    reg_rd && reg_addr == 9'h101 && $stable(config_fuse_lock_in)
    |=> reg_rdata_q[6] == $past(config_fuse_lock_in))
    else $error("Config lock bit differs from its source");
  a_emu_exit_clear: assert property (
    $fell(emul_active) ##1 !(reg_wr && reg_addr == 9'h101)
    ##1 (reg_rd && reg_addr == 9'h101) |=> !reg_rdata_q[3])
    else $error("Emulation done not cleared on exit");
  a_prog_cause: assert property (
    fuse_prog_q |-> $past(reg_wr) && $past(reg_addr) == 9'h103
    && fuse_wdata_q == $past(reg_wdata))
    else $error("Program pulse without a matching word write");
  a_fetch_pulse: assert property (fuse_rd_q |=> !fuse_rd_q)
    else $error("Fuse read request longer than one cycle");
  a_fetch_range: assert property (
    fuse_rd_q |-> fuse_addr_q inside {[8'h04:8'h18], [8'h20:8'h35]})
    else $error("Fuse read outside the load ranges");
  a_reload_start: assert property (
    reg_wr && reg_addr == 9'h101 && (reg_wdata[2] || reg_wdata[1]) |-> ##[2:4] fuse_rd_q)
    else $error("Reload trigger did not start a fetch");
  a_page_write: assert property (
    reg_wr && reg_addr == 9'h100 |=> page_select_q == $past(reg_wdata))
    else $error("Page select not written");
  c_prog: cover property (fuse_prog_q);
  c_emu_exit: cover property ($fell(emul_active));
  c_gen_flags: cover property (fuse_rd_q && fuse_addr_q == 8'h35);
endmodule // fuse_shadow_chk
bind fuse_shadow_load_control fuse_shadow_chk u_chk (
  .clk(clk),
  .nrst(nrst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q),
  .reg_rvalid_q(reg_rvalid_q),
  .config_fuse_lock_in(config_fuse_lock_in),
  .emul_active(emul_active),
  .fuse_rd_q(fuse_rd_q),
  .fuse_addr_q(fuse_addr_q),
  .fuse_read_margin_q(fuse_read_margin_q),
  .fuse_prog_q(fuse_prog_q),
  .fuse_wdata_q(fuse_wdata_q),
  .page_select_q(page_select_q)
);
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fuse_shadow_defines.vh"
// Compares a value with its expectation and counts the outcome
`define CMP(a, e) begin \
  checks++; \
  if ((a) !== (e)) begin \
    fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); \
  end \
end
module tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [8:0] addr = 9'h000;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic lock_in = 1'b0;
  logic emul = 1'b0;
  logic [7:0] f_rdata = 8'h00;
  logic f_rvalid = 1'b0;
  logic f_rd_d = 1'b0; // Fuse request one cycle late
  logic [7:0] f_addr_d = 8'h00;
  logic [7:0] flags = 8'h00; // Flag word served at a range end
  logic [7:0] got;
  wire [7:0] rdata;
  wire [7:0] f_addr;
  wire [7:0] f_wdata;
  wire rvalid;
  wire f_rd;
  wire margin;
  wire prog;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int progs = 0;
  int i;
  always #2.5 clk = ~clk;
  fuse_shadow_load_control dut (
    .clk(clk),
    .nrst(nrst),
    .reg_addr(addr),
    .reg_wdata(wdata),
    .reg_wr(wr_s),
    .reg_rd(rd_s),
    .reg_rdata_q(rdata),
    .reg_rvalid_q(rvalid),
    .config_fuse_lock_in(lock_in),
    .emul_active(emul),
    .fuse_rdata(f_rdata),
    .fuse_rvalid(f_rvalid),
    .fuse_rd_q(f_rd),
    .fuse_addr_q(f_addr),
    .fuse_read_margin_q(margin),
    .fuse_prog_q(prog),
    .fuse_wdata_q(f_wdata),
    .page_select_q()
  );
  ////////////////////////////////////////////////////////////////
  // Fuse stand-in answers two cycles late; also counts pulses and cuts hangs
  always @(posedge clk) begin
    f_rd_d <= f_rd;
    f_addr_d <= f_addr;
    f_rvalid <= f_rd_d;
    f_rdata <= (f_addr_d == 8'h18 || f_addr_d == 8'h35) ? flags : f_addr_d ^ 8'h5a;
    if (prog) progs++;
    cyc++;
    if (cyc > 20000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    if (fails == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Each access starts one edge on, so a strobe never toggles twice at once
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(posedge clk);
    #1;
    wr_s = 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    rd_s = 1'b1;
    @(posedge clk);
    #1;
    rd_s = 1'b0;
    `CMP(rvalid, 1'b1);
    d = rdata;
  endtask
  task automatic chk(input logic [8:0] a, input logic [7:0] e);
    rd(a, got);
    `CMP(got, e);
  endtask
  // Fires a reload and polls until its trigger bits fall back
  task automatic reload(input logic [7:0] bits, input logic [7:0] fl);
    int n;
    n = 0;
    flags = fl;
    wr(`REG_FUSE_CTRL, bits);
    got = bits;
    while ((got & bits) !== 8'h00 && n < 200) begin
      rd(`REG_FUSE_CTRL, got);
      n++;
    end
    `CMP(got & bits, 8'h00);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1;
    nrst = 1'b1;
    chk(`REG_FUSE_CTRL, `FUSE_CTRL_RESET);
    chk(`REG_PAGE_SELECT, `PAGE_SELECT_RESET);
    wr(`REG_FUSE_POINTER, 8'h00);
    for (i = 0; i < 3; i++) wr(`REG_FUSE_WORD, 8'h11);
    wr(`REG_FUSE_WORD, 8'h3c);
    // The pulse counter sees the program strobe one edge after it rises
    @(posedge clk);
    #1;
    `CMP(progs, 1);
    `CMP(f_wdata, 8'h3c);
    chk(`REG_FUSE_POINTER, 8'h00);
    wr(`REG_PAGE_SELECT, 8'h02);
    chk(`REG_PAGE_SELECT, 8'h02);
    wr(`REG_FUSE_CTRL, 8'hf1);
    `CMP(margin, 1'b1);
    chk(`REG_FUSE_CTRL, 8'h01);
    wr(`REG_FUSE_CTRL, 8'h00);
    `CMP(margin, 1'b0);
    lock_in = 1'b1;
    chk(`REG_FUSE_CTRL, 8'h40);
    emul = 1'b1;
    wr(`REG_FUSE_CTRL, 8'h08);
    chk(`REG_FUSE_CTRL, 8'h48);
    emul = 1'b0;
    @(posedge clk);
    #1;
    chk(`REG_FUSE_CTRL, 8'h40);
    wr(`ID_FIRST, 8'h33);
    chk(`ID_FIRST, 8'h33);
    wr(`APP_FIRST, 8'h77);
    chk(`APP_FIRST, 8'h00);
    reload(8'h04, 8'h20);
    chk(`APP_FIRST, 8'h5e);
    chk(`APP_LAST, 8'h4d);
    chk(`REG_FUSE_CTRL, 8'h60);
    reload(8'h02, 8'h90);
    chk(`GEN_FIRST, 8'h7a);
    chk(`GEN_LAST, 8'h6e);
    chk(`REG_FUSE_CTRL, 8'hf0);
    wr(`ID_FIRST, 8'h33);
    chk(`ID_FIRST, 8'h71);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
